// ---- verilog/tcf_pkg.sv ----
package tcf_pkg;
    // register addresses on the 8-bit i/o register bus
    localparam logic [7:0] TCF_ADDR_COMPARE_B   = 8'h28;
    localparam logic [7:0] TCF_ADDR_IRQ_MASK    = 8'h6E;
    localparam logic [7:0] TCF_ADDR_COMPARE_A   = 8'h27;
    localparam logic [7:0] TCF_ADDR_IRQ_FLAGS   = 8'h35;
    localparam logic [7:0] TCF_ADDR_COUNTER     = 8'h26;
    localparam logic [7:0] TCF_ADDR_CONTROL     = 8'h25;
    // field positions in mask, flag and control registers, and the number of sources
    localparam int         TCF_BIT_WRAP         = 0;
    localparam int         TCF_BIT_MATCH_A      = 1;
    localparam int         TCF_BIT_MATCH_B      = 2;
    localparam int         TCF_BIT_CLEAR_MATCH  = 3;
    localparam int         TCF_NUM_SRC          = 3;
    // reset values and the counter maximum
    localparam logic [7:0] TCF_RST_COMPARE      = 8'h00;
    localparam logic [7:0] TCF_RST_COUNTER      = 8'h00;
    localparam logic [2:0] TCF_RST_MASK         = 3'h0;
    localparam logic [2:0] TCF_RST_FLAGS        = 3'h0;
    localparam logic [7:0] TCF_COUNT_MAX        = 8'hFF;
endpackage

// ---- verilog/tcf_cmp_if.sv ----
`timescale 1ns/10ps
// compare results passed from the compare unit to the top
interface tcf_cmp_if;
    logic [7:0] counter_value;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic       block_match;
    logic       match_a;
    logic       match_b;
    modport top (output counter_value, output compare_a_value, output compare_b_value,
                 output block_match, input match_a, input match_b);
    modport cmp (input counter_value, input compare_a_value, input compare_b_value,
                 input block_match, output match_a, output match_b);
endinterface

// ---- verilog/tcf_compare.sv ----
`timescale 1ns/10ps
module tcf_compare (
    // compare operands and results
    tcf_cmp_if.cmp cmp
);
    // equality is checked at all times; a counter write masks it
    wire eq_a = (cmp.counter_value == cmp.compare_a_value);
    wire eq_b = (cmp.counter_value == cmp.compare_b_value);
    assign cmp.match_a = eq_a & ~cmp.block_match;
    assign cmp.match_b = eq_b & ~cmp.block_match;
endmodule // tcf_compare

// ---- verilog/tcf_timer.sv ----
`timescale 1ns/10ps
module tcf_timer (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // timer tick enable from the prescaler
    input  wire logic       timer_tick,
    // i/o register bus
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    // vector acknowledge from the cpu, one bit per source
    input  wire logic [2:0] vector_ack,
    // interrupt requests
    output logic      [2:0] irq_req,
    // counter state
    output logic      [7:0] counter_value
);
    import tcf_pkg::*;

    logic [7:0] counter_reg,   counter_next;
    logic [7:0] cmp_a_reg,     cmp_b_reg;
    logic [2:0] mask_reg;
    logic [2:0] flags_reg,     flags_next;
    logic       clr_match_reg;
    logic       block_reg;
    logic [7:0] rdata_next;

    tcf_cmp_if cmp_bus ();

    assign cmp_bus.counter_value   = counter_reg;
    assign cmp_bus.compare_a_value = cmp_a_reg;
    assign cmp_bus.compare_b_value = cmp_b_reg;
    assign cmp_bus.block_match     = block_reg;

    tcf_compare u_compare (
        .cmp (cmp_bus.cmp)
    );

    // address decode
    wire wr_counter = io_wr && (io_addr == TCF_ADDR_COUNTER);
    wire wr_cmp_a   = io_wr && (io_addr == TCF_ADDR_COMPARE_A);
    wire wr_cmp_b   = io_wr && (io_addr == TCF_ADDR_COMPARE_B);
    wire wr_mask    = io_wr && (io_addr == TCF_ADDR_IRQ_MASK);
    wire wr_flags   = io_wr && (io_addr == TCF_ADDR_IRQ_FLAGS);
    wire wr_ctrl    = io_wr && (io_addr == TCF_ADDR_CONTROL);

    // matches only count on a timer tick so a stopped timer never flags
    wire match_a_ev = timer_tick && cmp_bus.match_a;
    wire match_b_ev = timer_tick && cmp_bus.match_b;
    wire ctc_clear  = clr_match_reg && match_a_ev;
    // wrap detect
    // a cpu write in the same cycle replaces the count, so no wrap is flagged
    wire wrap_ev    = timer_tick && !ctc_clear && !wr_counter && (counter_reg == TCF_COUNT_MAX);

    // cpu write has priority over counting
    assign counter_next = wr_counter ? io_wdata :
                          ctc_clear  ? TCF_RST_COUNTER :
                          timer_tick ? 8'(counter_reg + 8'h01) : counter_reg;

    wire [2:0] hw_set;
    assign hw_set[TCF_BIT_WRAP]    = wrap_ev;
    assign hw_set[TCF_BIT_MATCH_A] = match_a_ev;
    assign hw_set[TCF_BIT_MATCH_B] = match_b_ev;

    wire [2:0] sw_clr = (wr_flags ? io_wdata[2:0] : 3'h0) | vector_ack;
    // set wins over clear
    // per source; a set in the same cycle as a clear keeps the flag
    for (genvar src = 0; src < TCF_NUM_SRC; src++) begin : g_src
        assign flags_next[src] = hw_set[src] | (flags_reg[src] & ~sw_clr[src]);
    end

    // a mask write reaches the request at the same edge as the mask itself
    wire [2:0] mask_next = wr_mask ? io_wdata[2:0] : mask_reg;

    assign rdata_next = (io_addr == TCF_ADDR_COUNTER)   ? counter_reg :
                        (io_addr == TCF_ADDR_COMPARE_A) ? cmp_a_reg :
                        (io_addr == TCF_ADDR_COMPARE_B) ? cmp_b_reg :
                        (io_addr == TCF_ADDR_IRQ_MASK)  ? {5'h00, mask_reg} :
                        (io_addr == TCF_ADDR_IRQ_FLAGS) ? {5'h00, flags_reg} :
                        (io_addr == TCF_ADDR_CONTROL)   ? {4'h0, clr_match_reg, 3'h0} : 8'h00;

    always_ff @(posedge clock) begin
        if (rst) begin
            counter_reg <= TCF_RST_COUNTER;
            flags_reg   <= TCF_RST_FLAGS;
        end else begin
            counter_reg <= counter_next;
            flags_reg   <= flags_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cmp_a_reg <= TCF_RST_COMPARE;
            cmp_b_reg <= TCF_RST_COMPARE;
        end else begin
            if (wr_cmp_a) cmp_a_reg <= io_wdata;
            if (wr_cmp_b) cmp_b_reg <= io_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mask_reg      <= TCF_RST_MASK;
            clr_match_reg <= 1'b0;
        end else begin
            if (wr_mask) mask_reg <= io_wdata[2:0];
            if (wr_ctrl) clr_match_reg <= io_wdata[TCF_BIT_CLEAR_MATCH];
        end
    end

    // block held until the next timer tick has passed
    always_ff @(posedge clock) begin
        if (rst)
            block_reg <= 1'b0;
        else if (wr_counter)
            block_reg <= 1'b1;
        else if (timer_tick)
            block_reg <= 1'b0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_req       <= 3'h0;
            io_rdata      <= 8'h00;
            counter_value <= TCF_RST_COUNTER;
        end else begin
            irq_req       <= flags_next & mask_next;
            io_rdata      <= io_rd ? rdata_next : 8'h00;
            counter_value <= counter_next;
        end
    end

    a_block_after_write: assert property (@(posedge clock) disable iff (rst)
        wr_counter ##1 (timer_tick && !wr_counter) |-> !cmp_bus.match_a && !cmp_bus.match_b)
        else $error("match not blocked after counter write");

    a_match_b_sets: assert property (@(posedge clock) disable iff (rst)
        match_b_ev |=> flags_reg[TCF_BIT_MATCH_B])
        else $error("match b flag not set");

    a_match_a_sets: assert property (@(posedge clock) disable iff (rst)
        match_a_ev |=> flags_reg[TCF_BIT_MATCH_A])
        else $error("match a flag not set");

    a_wrap_sets_flag: assert property (@(posedge clock) disable iff (rst)
        (timer_tick && !wr_counter && counter_reg == 8'hFF && !ctc_clear)
        |=> counter_reg == 8'h00 && flags_reg[TCF_BIT_WRAP])
        else $error("wrap flag not set with counter zero");

    a_ctc_clears: assert property (@(posedge clock) disable iff (rst)
        (ctc_clear && !wr_counter) |=> counter_reg == 8'h00)
        else $error("counter not cleared on compare a match");

    a_vector_clears: assert property (@(posedge clock) disable iff (rst)
        (vector_ack[TCF_BIT_MATCH_B] && !match_b_ev) |=> !flags_reg[TCF_BIT_MATCH_B])
        else $error("vector did not clear match b flag");

    a_w1c_clears: assert property (@(posedge clock) disable iff (rst)
        (wr_flags && io_wdata[1] && !match_a_ev) |=> !flags_reg[TCF_BIT_MATCH_A])
        else $error("write one did not clear match a flag");

    a_zero_keeps: assert property (@(posedge clock) disable iff (rst)
        (wr_flags && !io_wdata[0] && vector_ack == 3'h0) |=> flags_reg[0] >= $past(flags_reg[0]))
        else $error("writing zero cleared wrap flag");

    a_irq_gating: assert property (@(posedge clock) disable iff (rst)
        ##1 irq_req == (flags_reg & mask_reg))
        else $error("interrupt request not flag and mask");

    a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
        $past(io_rd && (io_addr == TCF_ADDR_IRQ_MASK || io_addr == TCF_ADDR_IRQ_FLAGS))
        |-> io_rdata[7:3] == 5'h00)
        else $error("reserved bits read non zero");

    a_match_a_flags: assert property (@(posedge clock) disable iff (rst)
        (timer_tick && !block_reg && counter_reg == cmp_a_reg) |=> flags_reg[TCF_BIT_MATCH_A])
        else $error("compare a equality not flagged");

    a_match_b_flags: assert property (@(posedge clock) disable iff (rst)
        (timer_tick && !block_reg && counter_reg == cmp_b_reg) |=> flags_reg[TCF_BIT_MATCH_B])
        else $error("compare b equality not flagged");

    a_cmp_a_write: assert property (@(posedge clock) disable iff (rst)
        wr_cmp_a |=> cmp_a_reg == $past(io_wdata))
        else $error("compare a write lost");

    a_cmp_b_write: assert property (@(posedge clock) disable iff (rst)
        wr_cmp_b |=> cmp_b_reg == $past(io_wdata))
        else $error("compare b write lost");

    a_mask_write: assert property (@(posedge clock) disable iff (rst)
        wr_mask |=> mask_reg == $past(io_wdata[2:0]))
        else $error("mask write lost");

    a_req_b_gate: assert property (@(posedge clock) disable iff (rst)
        irq_req[TCF_BIT_MATCH_B] == (flags_reg[TCF_BIT_MATCH_B] && mask_reg[TCF_BIT_MATCH_B]))
        else $error("match b request not gated by its enable");

    a_req_a_gate: assert property (@(posedge clock) disable iff (rst)
        irq_req[TCF_BIT_MATCH_A] == (flags_reg[TCF_BIT_MATCH_A] && mask_reg[TCF_BIT_MATCH_A]))
        else $error("match a request not gated by its enable");

    a_req_wrap_gate: assert property (@(posedge clock) disable iff (rst)
        irq_req[TCF_BIT_WRAP] == (flags_reg[TCF_BIT_WRAP] && mask_reg[TCF_BIT_WRAP]))
        else $error("wrap request not gated by its enable");

    a_w1c_match_b: assert property (@(posedge clock) disable iff (rst)
        (wr_flags && io_wdata[TCF_BIT_MATCH_B] && !match_b_ev) |=> !flags_reg[TCF_BIT_MATCH_B])
        else $error("write one did not clear match b flag");

    a_wrap_event: assert property (@(posedge clock) disable iff (rst)
        wrap_ev |=> flags_reg[TCF_BIT_WRAP])
        else $error("overflow did not set wrap flag");

    a_w1c_wrap: assert property (@(posedge clock) disable iff (rst)
        (wr_flags && io_wdata[TCF_BIT_WRAP] && !wrap_ev) |=> !flags_reg[TCF_BIT_WRAP])
        else $error("write one did not clear wrap flag");

    a_vector_wrap: assert property (@(posedge clock) disable iff (rst)
        (vector_ack[TCF_BIT_WRAP] && !wrap_ev) |=> !flags_reg[TCF_BIT_WRAP])
        else $error("vector did not clear wrap flag");

    a_vector_match_a: assert property (@(posedge clock) disable iff (rst)
        (vector_ack[TCF_BIT_MATCH_A] && !match_a_ev) |=> !flags_reg[TCF_BIT_MATCH_A])
        else $error("vector did not clear match a flag");

    a_free_count: assert property (@(posedge clock) disable iff (rst)
        (timer_tick && !wr_counter && !clr_match_reg) |=> counter_reg == 8'($past(counter_reg) + 8'h01))
        else $error("counter did not step freely");

    a_stopped_holds: assert property (@(posedge clock) disable iff (rst)
        (!timer_tick && !wr_counter) |=> counter_reg == $past(counter_reg))
        else $error("counter moved without a tick");

    a_block_set: assert property (@(posedge clock) disable iff (rst)
        wr_counter |=> block_reg)
        else $error("counter write did not arm match block");

    a_block_held: assert property (@(posedge clock) disable iff (rst)
        (block_reg && !timer_tick) |=> block_reg)
        else $error("match block dropped before a tick");

    a_set_beats_clear: assert property (@(posedge clock) disable iff (rst)
        (match_b_ev && wr_flags && io_wdata[TCF_BIT_MATCH_B]) |=> flags_reg[TCF_BIT_MATCH_B])
        else $error("software clear beat a hardware set");

    a_vector_set_wins: assert property (@(posedge clock) disable iff (rst)
        (vector_ack[TCF_BIT_MATCH_B] && match_b_ev) |=> flags_reg[TCF_BIT_MATCH_B])
        else $error("vector clear beat a hardware set");

    a_wrap_at_zero: assert property (@(posedge clock) disable iff (rst)
        $rose(flags_reg[TCF_BIT_WRAP]) |-> counter_reg == TCF_RST_COUNTER)
        else $error("wrap flag rose with counter not zero");

endmodule // tcf_timer

// ---- tb/tcf_cpu_model.sv ----
`timescale 1ns/10ps
module tcf_cpu_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // core controls
    input  wire logic       gie,
    input  wire logic       slow,
    // interrupt side
    input  wire logic [2:0] irq_req,
    output logic      [2:0] vector_ack
);
    logic       [2:0] wait_reg;
    wire  logic [2:0] taken = irq_req & {3{gie}} & ~vector_ack;
    always_ff @(posedge clock) begin
        if (rst) begin
            wait_reg   <= 3'h0;
            vector_ack <= 3'h0;
        end else begin
            wait_reg   <= slow ? wait_reg + 3'h1 : 3'h0;
            vector_ack <= (!slow || wait_reg == 3'h7) ? taken : 3'h0;
        end
    end
endmodule // tcf_cpu_model

// ---- tb/tcf_timer_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, a, e); end end
module tcf_timer_tb;
    import tcf_pkg::*;
    logic       clock = 1'h0, rst = 1'h1, timer_tick = 1'h0, io_wr = 1'h0, io_rd = 1'h0;
    logic       gie = 1'h0, slow = 1'h0, rd_pend = 1'h0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, cnt, exp_v;
    logic [31:0] seed;
    logic [2:0] vector_ack, irq_req;
    logic [7:0] exp_q[$];
    int         n_fail = 0, total_checks = 0;

    tcf_timer dut_u (.clock(clock), .rst(rst), .timer_tick(timer_tick), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .vector_ack(vector_ack),
        .irq_req(irq_req), .counter_value(cnt));
    tcf_cpu_model cpu_u (.clock(clock), .rst(rst), .gie(gie), .slow(slow), .irq_req(irq_req),
        .vector_ack(vector_ack));

    initial begin
        forever #5 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'h1;
        @(negedge clock);
        io_wr = 1'h0;
    endtask

    // the expectation is queued; the watcher below compares it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        exp_q.push_back(e);
        io_addr = a;
        io_rd   = 1'h1;
        @(negedge clock);
        io_rd = 1'h0;
    endtask

    task automatic tk(input int n);
        @(negedge clock);
        timer_tick = 1'h1;
        repeat (n) @(negedge clock);
        timer_tick = 1'h0;
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // read data is registered at the read edge and checked on the next falling edge
    always @(posedge clock) rd_pend <= io_rd;
    always @(negedge clock) begin
        if (rd_pend) begin
            exp_v = exp_q.pop_front();
            `CHK(io_rdata, exp_v)
        end
    end

    initial begin
        #20000;
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (6) @(negedge clock);
        rst = 1'h0;
        rd(TCF_ADDR_COMPARE_B, 8'h00);
        rd(TCF_ADDR_IRQ_FLAGS, 8'h00);
        wr(TCF_ADDR_IRQ_MASK, 8'hFF);
        rd(TCF_ADDR_IRQ_MASK, 8'h07);
        seed = 32'h91F472D8;
        repeat (4) begin
            seed = lfsr(seed);
            wr(TCF_ADDR_COMPARE_B, seed[7:0]);
            rd(TCF_ADDR_COMPARE_B, seed[7:0]);
        end
        wr(TCF_ADDR_COMPARE_A, 8'h10);
        wr(TCF_ADDR_COMPARE_B, 8'h20);
        wr(TCF_ADDR_COUNTER, 8'hFE);
        tk(2);
        rd(TCF_ADDR_COUNTER, 8'h00);
        rd(TCF_ADDR_IRQ_FLAGS, 8'h01);
        `CHK(irq_req, 3'h1)
        wr(TCF_ADDR_IRQ_FLAGS, 8'h01);
        rd(TCF_ADDR_IRQ_FLAGS, 8'h00);
        tk(17);
        rd(TCF_ADDR_IRQ_FLAGS, 8'h02);
        slow = 1'h1;
        gie  = 1'h1;
        repeat (14) @(negedge clock);
        gie = 1'h0;
        rd(TCF_ADDR_IRQ_FLAGS, 8'h00);
        tk(16);
        wr(TCF_ADDR_IRQ_FLAGS, 8'h00);
        rd(TCF_ADDR_IRQ_FLAGS, 8'h04);
        wr(TCF_ADDR_IRQ_FLAGS, 8'h04);
        rd(TCF_ADDR_IRQ_FLAGS, 8'h00);
        slow = 1'h0;
        wr(TCF_ADDR_COUNTER, 8'h1F);
        tk(2);
        wr(TCF_ADDR_COUNTER, 8'hFF);
        tk(1);
        rd(TCF_ADDR_IRQ_FLAGS, 8'h05);
        wr(TCF_ADDR_IRQ_MASK, 8'h01);
        `CHK(irq_req, 3'h1)
        gie = 1'h1;
        repeat (3) @(negedge clock);
        rd(TCF_ADDR_IRQ_FLAGS, 8'h04);
        wr(TCF_ADDR_IRQ_MASK, 8'hFF);
        repeat (3) @(negedge clock);
        gie = 1'h0;
        rd(TCF_ADDR_IRQ_FLAGS, 8'h00);
        wr(TCF_ADDR_COUNTER, 8'h10);
        tk(1);
        rd(TCF_ADDR_IRQ_FLAGS, 8'h00);
        wr(TCF_ADDR_CONTROL, 8'h08);
        wr(TCF_ADDR_COMPARE_A, 8'h05);
        wr(TCF_ADDR_COUNTER, 8'h00);
        tk(8);
        rd(TCF_ADDR_COUNTER, 8'h02);
        `CHK(cnt, 8'h02)
        repeat (3) @(negedge clock);
        end_of_test();
    end
endmodule // tcf_timer_tb
